// ### inc/tpcm_pkg.sv
// Constants and carriers for the 10-bit timer in PWM, single pulse and capture modes.
// Assumes a single 100 MHz clock; the timer tick arrives as a one-cycle enable.
// How it works
// - Swap set in PWM: period is compare A, duty is P*128, or 1024 when P is 0.
// - Swap set: compare A match clears counter and starts a new PWM period.
// - PWM keeps running while pin function is 00 or 01; pin forced.
// - Clear source select has no effect on PWM operation.
// - Single pulse: on bit rising starts counter and gives pulse leading edge.
// - Single pulse: external trigger pin active edge sets the on bit.
// - Single pulse: compare A match or software clear ends the pulse.
// - Single pulse: compare A match raises timer interrupt request.
// - Single pulse: counter zeroed only on on-bit rise; P, clear select, swap ignored.
// - Capture trigger selectable as rising, falling or both edges.
// - Active capture edge copies counter into compare A and raises interrupt.
// - Capture: counter keeps counting until the on bit falls.
// - Capture: P match zeroes counter, raises interrupt; P of zero gives full range.
// - Capture: pin function 11 disables capture, counter still runs.
// - Capture pulses under 2 timer clocks may be ignored.
// - Copy two clocks after the sampled edge; A flag one clock after.
// - Capture needs a running timer clock; initial level and polarity unused.
// - On bit rising returns output pin to the initial level, except in single pulse and capture.
// - Polarity bit inverts the PWM waveform on the pin.
// - Duty at or above period keeps output active the whole period.
package tpcm_pkg;
  localparam int unsigned CNT_W        = 10;
  localparam logic [9:0]  CNT_RST      = 10'h000;
  localparam logic [9:0]  CNT_MAX      = 10'h3FF;
  localparam logic [10:0] FULL_PERIOD  = 11'h400;
  localparam int unsigned P_SHIFT      = 7;
  localparam logic [2:0]  P_RST        = 3'h0;
  localparam int unsigned SYNC_STAGES  = 2;

  typedef enum logic [1:0]
  {
    TPCM_MODE_CMP  = 2'b00,
    TPCM_MODE_CAP  = 2'b01,
    TPCM_MODE_PWM  = 2'b10,
    TPCM_MODE_TMR  = 2'b11
  } tpcm_mode_e;

  typedef enum logic [1:0]
  {
    TPCM_PF_INACT  = 2'b00,
    TPCM_PF_ACT    = 2'b01,
    TPCM_PF_PWM    = 2'b10,
    TPCM_PF_SINGLE = 2'b11
  } tpcm_pinfn_e;

  typedef struct packed
  {
    tpcm_mode_e  mode;
    tpcm_pinfn_e pin_function;
    logic        output_initial_level;
    logic        output_polarity_invert;
    logic        clear_source_select;
    logic        duty_period_swap;
  } tpcm_ctrl_s;

  typedef struct packed
  {
    logic match_a;
    logic match_p;
    logic capture;
  } tpcm_evt_s;
endpackage : tpcm_pkg

// ### rtl/tpcm_sync.sv
// Two-flop synchroniser for one asynchronous pin.
// Assumes the pin is slow against sys_clk.
`timescale 1ns/1ps
`default_nettype none
module tpcm_sync
(
  input  wire logic sys_clk,
  input  wire logic rst_n,
  input  wire logic pin_async,
  output logic      pin_sync
);
  logic meta_reg;

  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      meta_reg <= 1'b0;
      pin_sync <= 1'b0;
    end
    else
    begin
      meta_reg <= pin_async;
      pin_sync <= meta_reg;
    end
  end
endmodule : tpcm_sync
`default_nettype wire

// ### rtl/tpcm_edge.sv
// Edge detector on a synchronised level, sampled on the timer tick.
// Assumes the input already passed a synchroniser.
`timescale 1ns/1ps
`default_nettype none
module tpcm_edge
(
  input  wire logic sys_clk,
  input  wire logic rst_n,
  input  wire logic tick,
  input  wire logic level,
  output logic      rise,
  output logic      fall
);
  logic last_reg;

  // Sampled on tick so narrow pulses between ticks vanish
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
      last_reg <= 1'b0;
    else if (tick)
      last_reg <= level;
  end

  assign rise = tick & level & ~last_reg;
  assign fall = tick & ~level & last_reg;
endmodule : tpcm_edge
`default_nettype wire

// ### rtl/tpcm_timer.sv
// Timer core: PWM with period/duty swap, single pulse and capture input.
// Assumes timer_tick is a one-cycle enable from the clock divider; pins are asynchronous.
`timescale 1ns/1ps
`default_nettype none
module tpcm_timer
(
  input  wire logic                sys_clk,
  input  wire logic                rst_n,
  input  wire logic                timer_tick,
  input  wire tpcm_pkg::tpcm_ctrl_s ctrl,
  input  wire logic [9:0]          compare_a_wr_value,
  input  wire logic                compare_a_wr,
  input  wire logic [2:0]          compare_p_value,
  input  wire logic                counter_on_set,
  input  wire logic                counter_on_clr,
  input  wire logic                external_trigger_clock_pin,
  input  wire logic                capture_input_pin,
  output logic                     counter_on,
  output logic [9:0]               counter_value,
  output logic [9:0]               compare_a_value,
  output logic                     match_a_flag,
  output logic                     match_p_flag,
  output logic                     timer_irq,
  output logic                     timer_out
);
  logic        trig_sync;
  logic        cap_sync;
  logic        trig_rise;
  logic        cap_rise;
  logic        cap_fall;
  logic        on_last_reg;
  logic        on_rise;
  logic        is_pwm;
  logic        is_single;
  logic        is_cap;
  logic        match_a;
  logic        match_p;
  logic        cap_edge;
  logic        cap_pending_reg;
  logic        flag_a_pending_reg;
  logic [9:0]  cnt_next;
  logic [10:0] period_len;
  logic [10:0] duty_len;
  logic [10:0] cnt_ext;
  logic [10:0] cnt_inc;
  logic        pwm_active;
  logic        wave_reg;
  logic        p_zero;

  tpcm_sync u_trig_sync
  (
    .sys_clk   (sys_clk),
    .rst_n     (rst_n),
    .pin_async (external_trigger_clock_pin),
    .pin_sync  (trig_sync)
  );

  tpcm_sync u_cap_sync
  (
    .sys_clk   (sys_clk),
    .rst_n     (rst_n),
    .pin_async (capture_input_pin),
    .pin_sync  (cap_sync)
  );

  tpcm_edge u_trig_edge
  (
    .sys_clk (sys_clk),
    .rst_n   (rst_n),
    .tick    (timer_tick),
    .level   (trig_sync),
    .rise    (trig_rise),
    .fall    ()
  );

  // Edge seen only at ticks, so sub-2-tick pulses can be missed
  tpcm_edge u_cap_edge
  (
    .sys_clk (sys_clk),
    .rst_n   (rst_n),
    .tick    (timer_tick),
    .level   (cap_sync),
    .rise    (cap_rise),
    .fall    (cap_fall)
  );

  assign is_pwm    = (ctrl.mode == tpcm_pkg::TPCM_MODE_PWM) && (ctrl.pin_function != tpcm_pkg::TPCM_PF_SINGLE);
  assign is_single = (ctrl.mode == tpcm_pkg::TPCM_MODE_PWM) && (ctrl.pin_function == tpcm_pkg::TPCM_PF_SINGLE);
  assign is_cap    = (ctrl.mode == tpcm_pkg::TPCM_MODE_CAP);
  assign p_zero    = (compare_p_value == tpcm_pkg::P_RST);

  // Period and duty lengths; clear_source_select never enters here
  always_comb
  begin
    if (ctrl.duty_period_swap)
    begin
      period_len = {1'b0, compare_a_value};
      duty_len   = p_zero ? tpcm_pkg::FULL_PERIOD
                          : {1'b0, compare_p_value, 7'h00};
    end
    else
    begin
      period_len = p_zero ? tpcm_pkg::FULL_PERIOD : {1'b0, compare_p_value, 7'h00};
      duty_len   = {1'b0, compare_a_value};
    end
  end

  assign cnt_ext = {1'b0, counter_value};
  assign cnt_inc = cnt_ext + 11'h001;
  // Match on the value the tick reaches: N counts per clear; 0 never matches
  // Masked on start, where the held count is stale
  assign match_a = timer_tick && counter_on && !on_rise && (cnt_inc == {1'b0, compare_a_value});
  assign match_p = timer_tick && counter_on && !on_rise && !p_zero
                   && (cnt_inc == {1'b0, compare_p_value, 7'h00});

  // On-bit: software set/clear; in single pulse also set by external trigger, cleared by match A
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
      counter_on <= 1'b0;
    else if (counter_on_set || (is_single && trig_rise))
      counter_on <= 1'b1;
    else if (counter_on_clr || (is_single && match_a))
      counter_on <= 1'b0;
  end

  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
      on_last_reg <= 1'b0;
    else
      on_last_reg <= counter_on;
  end

  assign on_rise      = counter_on && !on_last_reg;

  // Counter next value per mode
  always_comb
  begin
    cnt_next = counter_value;
    if (on_rise)
      cnt_next = tpcm_pkg::CNT_RST;
    else if (timer_tick && counter_on)
    begin
      if (is_pwm)
      begin
        if ((cnt_ext + 11'h001) >= period_len)
          cnt_next = tpcm_pkg::CNT_RST;
        else
          cnt_next = counter_value + 10'h001;
      end
      else if (is_cap && match_p)
        cnt_next = tpcm_pkg::CNT_RST;
      else if (is_single && match_a)
        cnt_next = counter_value;
      else
        cnt_next = counter_value + 10'h001;
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
      counter_value <= tpcm_pkg::CNT_RST;
    else
      counter_value <= cnt_next;
  end

  // Capture edge select; code 11 disables capture only
  always_comb
  begin
    case (ctrl.pin_function)
      tpcm_pkg::TPCM_PF_INACT:  cap_edge = cap_rise;
      tpcm_pkg::TPCM_PF_ACT:    cap_edge = cap_fall;
      tpcm_pkg::TPCM_PF_PWM:    cap_edge = cap_rise | cap_fall;
      tpcm_pkg::TPCM_PF_SINGLE: cap_edge = 1'b0;
      default:                  cap_edge = 1'b0;
    endcase
  end

  // Capture copied two clocks after the edge, flag one clock later
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
      cap_pending_reg <= 1'b0;
    else
      cap_pending_reg <= is_cap && counter_on && cap_edge;
  end

  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
      compare_a_value <= tpcm_pkg::CNT_RST;
    else if (cap_pending_reg)
      compare_a_value <= counter_value;
    else if (compare_a_wr)
      compare_a_value <= compare_a_wr_value;
  end

  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
      flag_a_pending_reg <= 1'b0;
    else
      flag_a_pending_reg <= cap_pending_reg;
  end

  // Flags are one-cycle event pulses; irq is the OR
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      match_a_flag <= 1'b0;
      match_p_flag <= 1'b0;
      timer_irq    <= 1'b0;
    end
    else
    begin
      match_a_flag <= flag_a_pending_reg || (!is_cap && match_a);
      match_p_flag <= match_p && !is_single;
      timer_irq    <= flag_a_pending_reg || (!is_cap && match_a) || (match_p && !is_single);
    end
  end

  // PWM active while counter below duty; duty >= period stays active
  assign pwm_active = (duty_len >= period_len) || (cnt_ext < duty_len);

  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
      wave_reg <= 1'b0;
    else if (on_rise)
      wave_reg <= 1'b1;
    else if (is_single)
      wave_reg <= counter_on;
    else
      wave_reg <= pwm_active;
  end

  // Output pin; low in capture; initial level on on-bit rise outside single pulse, forced levels in 00/01
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
      timer_out <= 1'b0;
    else if (is_cap)
      timer_out <= 1'b0;
    else if (on_rise && !is_single)
      timer_out <= ctrl.output_initial_level;
    else if (!counter_on && !is_single)
      timer_out <= timer_out;
    else
    begin
      case (ctrl.pin_function)
        tpcm_pkg::TPCM_PF_INACT: timer_out <= ~ctrl.output_initial_level;
        tpcm_pkg::TPCM_PF_ACT:   timer_out <= ctrl.output_initial_level;
        default:                 timer_out <= (wave_reg ~^ ctrl.output_initial_level)
                                              ^ ctrl.output_polarity_invert;
      endcase
    end
  end

  // Checks
  single_stop_a : assert property (@(posedge sys_clk) disable iff (!rst_n)
    is_single && match_a && !counter_on_set && !trig_rise |=> !counter_on)
    else $error("single pulse did not stop on match A");

  trig_start_a : assert property (@(posedge sys_clk) disable iff (!rst_n)
    is_single && trig_rise |=> counter_on)
    else $error("trigger did not set on bit");

  on_zero_a : assert property (@(posedge sys_clk) disable iff (!rst_n)
    on_rise |=> counter_value == tpcm_pkg::CNT_RST)
    else $error("counter not zeroed on start");

  cap_copy_a : assert property (@(posedge sys_clk) disable iff (!rst_n)
    is_cap && counter_on && cap_edge && !on_rise |=> ##1 compare_a_value == $past(counter_value))
    else $error("capture did not copy counter");

  cap_flag_a : assert property (@(posedge sys_clk) disable iff (!rst_n)
    is_cap && counter_on && cap_edge |=> ##2 match_a_flag && timer_irq)
    else $error("capture flag late");

  cap_off_a : assert property (@(posedge sys_clk) disable iff (!rst_n)
    is_cap && ctrl.pin_function == tpcm_pkg::TPCM_PF_SINGLE && $stable(ctrl) |=> !cap_pending_reg)
    else $error("capture while disabled");

  p_clear_a : assert property (@(posedge sys_clk) disable iff (!rst_n)
    is_cap && match_p && !on_rise |=> counter_value == tpcm_pkg::CNT_RST && match_p_flag)
    else $error("P match did not clear counter");

  swap_wrap_a : assert property (@(posedge sys_clk) disable iff (!rst_n)
    is_pwm && ctrl.duty_period_swap && timer_tick && counter_on && !on_rise
    && (cnt_ext + 11'h001 >= period_len) |=> counter_value == tpcm_pkg::CNT_RST)
    else $error("swap period did not wrap on A");

  count_run_a : assert property (@(posedge sys_clk) disable iff (!rst_n)
    is_cap && counter_on && timer_tick && !match_p && !on_rise && !counter_on_clr
    |=> counter_value == $past(counter_value) + 10'h001)
    else $error("capture counter stalled");

  pwm_duty_a : assert property (@(posedge sys_clk) disable iff (!rst_n)
    is_pwm && counter_on && !on_rise && (duty_len >= period_len) |=> wave_reg)
    else $error("full duty not held active");

  pin_inact_a : assert property (@(posedge sys_clk) disable iff (!rst_n)
    is_pwm && counter_on && !on_rise && ctrl.pin_function == tpcm_pkg::TPCM_PF_INACT
    |=> timer_out != $past(ctrl.output_initial_level))
    else $error("forced inactive level wrong");

  pin_act_a : assert property (@(posedge sys_clk) disable iff (!rst_n)
    is_pwm && counter_on && !on_rise && ctrl.pin_function == tpcm_pkg::TPCM_PF_ACT
    |=> timer_out == $past(ctrl.output_initial_level))
    else $error("forced active level wrong");

  pwm_run_a : assert property (@(posedge sys_clk) disable iff (!rst_n)
    is_pwm && ctrl.pin_function != tpcm_pkg::TPCM_PF_PWM && counter_on && timer_tick && !on_rise
    && cnt_inc < period_len |=> counter_value == $past(counter_value) + 10'h001)
    else $error("PWM counter stopped while pin forced");

  single_hold_a : assert property (@(posedge sys_clk) disable iff (!rst_n)
    is_single && !counter_on |=> counter_value == $past(counter_value))
    else $error("single pulse counter moved while off");

  single_count_a : assert property (@(posedge sys_clk) disable iff (!rst_n)
    is_single && counter_on && timer_tick && !on_rise && !match_a
    |=> counter_value == $past(counter_value) + 10'h001)
    else $error("single pulse counter not counting");

  single_irq_a : assert property (@(posedge sys_clk) disable iff (!rst_n)
    is_single && match_a |=> match_a_flag && timer_irq)
    else $error("single pulse match gave no request");

  single_idle_a : assert property (@(posedge sys_clk) disable iff (!rst_n)
    is_single && !counter_on ##1 is_single && !counter_on && $stable(ctrl)
    |=> timer_out != ($past(ctrl.output_initial_level) ^ $past(ctrl.output_polarity_invert)))
    else $error("idle single pulse pin not inactive");

  on_init_a : assert property (@(posedge sys_clk) disable iff (!rst_n)
    on_rise && !is_single && !is_cap |=> timer_out == $past(ctrl.output_initial_level))
    else $error("pin not set to initial level on start");

  cap_nopin_a : assert property (@(posedge sys_clk) disable iff (!rst_n)
    is_cap |=> !timer_out)
    else $error("pin driven in capture mode");

  tick_gate_a : assert property (@(posedge sys_clk) disable iff (!rst_n)
    !timer_tick && !on_rise |=> counter_value == $past(counter_value))
    else $error("counter moved without a tick");

  cap_hold_a : assert property (@(posedge sys_clk) disable iff (!rst_n)
    !cap_pending_reg && !compare_a_wr |=> compare_a_value == $past(compare_a_value))
    else $error("compare A changed without capture or write");
endmodule : tpcm_timer
`default_nettype wire

// ### verification/tpcm_pin_model.sv
// Pin model around the timer: trigger source and capture input source.
// Assumes callers act shortly after a rising clock edge.
`timescale 1ns/1ps
`default_nettype none
module tpcm_pin_model
(
  input  wire logic sys_clk,
  output logic      trig_pin,
  output logic      cap_pin
);
  initial
  begin
    trig_pin = 1'b0;
    cap_pin  = 1'b0;
  end
  // Held 4 clocks so the edge survives the synchroniser
  task automatic pulse_trig();
    trig_pin = 1'b1;
    repeat (4) @(posedge sys_clk);
    #1;
    trig_pin = 1'b0;
  endtask : pulse_trig
  // Caller keeps levels at least 20 clocks apart
  task automatic set_cap(input logic v);
    cap_pin = v;
  endtask : set_cap
endmodule : tpcm_pin_model
`default_nettype wire

// ### verification/tpcm_timer_tb.sv
// Bench for the timer core in capture, PWM and single pulse modes.
// Assumes a tick on every clock but in one stopped-clock check; pins come from tpcm_pin_model.
`timescale 1ns/1ps
`default_nettype none
module tpcm_timer_tb;
  logic                 sys_clk = 1'b0;
  logic                 rst_n;
  logic                 tick;
  tpcm_pkg::tpcm_ctrl_s ctrl;
  logic [9:0]           a_val;
  logic                 a_wr;
  logic [2:0]           p_val;
  logic                 on_set;
  logic                 on_clr;
  logic                 trig_pin;
  logic                 cap_pin;
  logic                 counter_on;
  logic [9:0]           counter_value;
  logic [9:0]           compare_a_value;
  logic                 match_a_flag;
  logic                 match_p_flag;
  logic                 timer_irq;
  logic                 timer_out;
  int                   failures = 0;
  int                   n_tests  = 0;
  int                   wt;
  int                   hi;
  int                   w;
  int                   n;
  int                   pw [2];
  logic [9:0]           c0;
  logic [9:0]           d;
  always #5 sys_clk = ~sys_clk;
  // Tick high except where a stopped timer clock is checked
  tpcm_timer i_tpcm_timer (.sys_clk(sys_clk), .rst_n(rst_n), .timer_tick(tick), .ctrl(ctrl),
    .compare_a_wr_value(a_val), .compare_a_wr(a_wr), .compare_p_value(p_val), .counter_on_set(on_set),
    .counter_on_clr(on_clr), .external_trigger_clock_pin(trig_pin), .capture_input_pin(cap_pin),
    .counter_on(counter_on), .counter_value(counter_value), .compare_a_value(compare_a_value),
    .match_a_flag(match_a_flag), .match_p_flag(match_p_flag), .timer_irq(timer_irq), .timer_out(timer_out));
  tpcm_pin_model i_tpcm_pin_model (.sys_clk(sys_clk), .trig_pin(trig_pin), .cap_pin(cap_pin));
  task automatic summarize();
    if (failures == 0 && n_tests > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : summarize
  task automatic step(input int k);
    repeat (k) @(posedge sys_clk);
    #1;
  endtask : step
  task automatic cmp(input logic [10:0] got, input logic [10:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      failures++;
      $display("ERROR t=%0t got=%0h exp=%0h", $time, got, exp);
    end
  endtask : cmp
  function automatic logic pick(input int sel);
    case (sel)
      0:       return match_a_flag;
      1:       return match_p_flag;
      default: return counter_on;
    endcase
  endfunction : pick
  // Counts cycles and active output cycles until the selected signal is high
  task automatic wait_on(input int sel);
    wt = 0;
    hi = 0;
    while (pick(sel) !== 1'b1)
    begin
      if (timer_out === 1'b1)
        hi++;
      step(1);
      wt++;
      if (wt > 3000)
      begin
        failures++;
        summarize();
      end
    end
  endtask : wait_on
  task automatic count(input int sel, input int k);
    n = 0;
    repeat (k)
    begin
      step(1);
      if (pick(sel) === 1'b1)
        n++;
    end
  endtask : count
  task automatic pulse_on(input logic s);
    on_set = s;
    on_clr = ~s;
    step(1);
    on_set = 1'b0;
    on_clr = 1'b0;
  endtask : pulse_on
  task automatic wr_a(input logic [9:0] v);
    a_val = v;
    a_wr  = 1'b1;
    step(1);
    a_wr  = 1'b0;
  endtask : wr_a
  // Second of two periods, so a settings change has settled
  task automatic pwm_case(input tpcm_pkg::tpcm_pinfn_e pf, input logic pol, input logic css,
                          input logic [2:0] p, input logic [10:0] exp_hi);
    ctrl.pin_function           = pf;
    ctrl.output_polarity_invert = pol;
    ctrl.clear_source_select    = css;
    p_val                       = p;
    repeat (2)
    begin
      wait_on(0);
      w = (timer_out === 1'b1) ? 1 : 0;
      step(1);
      wait_on(0);
    end
    cmp(11'(wt + 1), 11'h0C8);
    cmp(11'(hi + w), exp_hi);
  endtask : pwm_case
  initial
  begin
    rst_n  = 1'b0;
    tick   = 1'b1;
    ctrl   = '0;
    a_val  = 10'h000;
    a_wr   = 1'b0;
    p_val  = 3'h0;
    on_set = 1'b0;
    on_clr = 1'b0;
    step(2);
    rst_n = 1'b1;
    cmp(11'(timer_out), 11'h000);
    cmp(11'(counter_value), 11'h000);
    ctrl.mode = tpcm_pkg::TPCM_MODE_CAP;
    pulse_on(1'b1);
    step(5);
    i_tpcm_pin_model.set_cap(1'b1);
    wait_on(0);
    cmp(11'(timer_irq), 11'h001);
    step(20);
    i_tpcm_pin_model.set_cap(1'b0);
    count(0, 30);
    cmp(11'(n), 11'h000);
    ctrl.pin_function = tpcm_pkg::TPCM_PF_ACT;
    i_tpcm_pin_model.set_cap(1'b1);
    count(0, 30);
    cmp(11'(n), 11'h000);
    i_tpcm_pin_model.set_cap(1'b0);
    wait_on(0);
    w = wt;
    c0 = compare_a_value;
    ctrl.pin_function = tpcm_pkg::TPCM_PF_PWM;
    step(20);
    i_tpcm_pin_model.set_cap(1'b1);
    wait_on(0);
    d = compare_a_value - c0;
    cmp(11'(d), 11'(20 + w));
    step(20);
    i_tpcm_pin_model.set_cap(1'b0);
    wait_on(0);
    ctrl.pin_function = tpcm_pkg::TPCM_PF_SINGLE;
    step(20);
    i_tpcm_pin_model.set_cap(1'b1);
    count(0, 30);
    cmp(11'(n), 11'h000);
    c0 = counter_value;
    step(3);
    d = counter_value - c0;
    cmp(11'(d), 11'h003);
    tick = 1'b0;
    c0 = counter_value;
    step(5);
    cmp(11'(counter_value), 11'(c0));
    tick = 1'b1;
    ctrl.pin_function = tpcm_pkg::TPCM_PF_INACT;
    pulse_on(1'b0);
    p_val = 3'h1;
    pulse_on(1'b1);
    wait_on(1);
    step(1);
    wait_on(1);
    cmp(11'(wt + 1), 11'h080);
    cmp(11'(timer_irq), 11'h001);
    pulse_on(1'b0);
    step(1);
    c0 = counter_value;
    step(5);
    cmp(11'(counter_value), 11'(c0));
    ctrl.mode                 = tpcm_pkg::TPCM_MODE_PWM;
    ctrl.duty_period_swap     = 1'b1;
    ctrl.output_initial_level = 1'b1;
    wr_a(10'h0C8);
    pulse_on(1'b1);
    pwm_case(tpcm_pkg::TPCM_PF_PWM, 1'b0, 1'b0, 3'h1, 11'h080);
    pwm_case(tpcm_pkg::TPCM_PF_PWM, 1'b0, 1'b1, 3'h1, 11'h080);
    pwm_case(tpcm_pkg::TPCM_PF_PWM, 1'b1, 1'b0, 3'h1, 11'h048);
    pwm_case(tpcm_pkg::TPCM_PF_PWM, 1'b0, 1'b0, 3'h0, 11'h0C8);
    pwm_case(tpcm_pkg::TPCM_PF_INACT, 1'b0, 1'b0, 3'h1, 11'h000);
    pwm_case(tpcm_pkg::TPCM_PF_ACT, 1'b0, 1'b0, 3'h1, 11'h0C8);
    pulse_on(1'b0);
    ctrl.pin_function           = tpcm_pkg::TPCM_PF_SINGLE;
    ctrl.output_polarity_invert = 1'b0;
    for (int i = 0; i < 2; i++)
    begin
      wr_a(i == 0 ? 10'h032 : 10'h050);
      i_tpcm_pin_model.pulse_trig();
      wait_on(2);
      wait_on(0);
      pw[i] = hi;
      cmp(11'(timer_irq), 11'h001);
      step(2);
      cmp(11'(counter_on), 11'h000);
      cmp(11'(timer_out), 11'h000);
    end
    cmp(11'(pw[1] - pw[0]), 11'h01E);
    c0 = counter_value;
    step(5);
    cmp(11'(counter_value), 11'(c0));
    // Pin follows the on bit two clocks late
    pulse_on(1'b1);
    step(2);
    cmp(11'(counter_value < 10'h003), 11'h001);
    cmp(11'(timer_out), 11'h001);
    pulse_on(1'b0);
    step(2);
    cmp(11'(timer_out), 11'h000);
    summarize();
  end
endmodule : tpcm_timer_tb
`default_nettype wire
